/* File: hdl/wdc_pkg.sv */
package wdc_pkg;
  localparam int PWM_PERIOD_CYC = 1000;
  localparam int BLANK_CYC = 200;
  localparam int MIX_PCT = 75;
  localparam int PCT_FULL = 100;
  localparam int CNT_W = 16;
  localparam int MIX_POINT_CYC = PWM_PERIOD_CYC * MIX_PCT / PCT_FULL;

  // gate patterns {hiA, loA, hiB, loB}
  localparam logic [3:0] GATE_OFF = 4'h0;
  localparam logic [3:0] GATE_POS = 4'h9;
  localparam logic [3:0] GATE_NEG = 4'h6;
  localparam logic [3:0] GATE_LOWS = 4'h5;

  // synchroniser reset levels; output enable idles at its off level
  localparam logic [6:0] PIN_SYNC_RST = 7'h01;

  // decay mode, one-hot; decoded from the {driven, level} pins
  typedef enum logic [2:0] {
    DEC_SLOW = 3'b001,
    DEC_FAST = 3'b010,
    DEC_MIXED = 3'b100
  } wdc_decay_type;

  // per-winding bridge command
  typedef enum logic [2:0] {
    BR_OFF = 3'b000,
    BR_DRIVE = 3'b001,
    BR_REVERSE = 3'b010,
    BR_BRAKE = 3'b100
  } wdc_bridge_type;
endpackage

/* File: hdl/wdc_timer_if.sv */
interface wdc_timer_if;
  import wdc_pkg::*;
  logic periodStart;
  logic inBlank;
  logic pastMix;
  modport source (output periodStart, output inBlank, output pastMix);
  modport sink (input periodStart, input inBlank, input pastMix);
endinterface

/* File: hdl/wdc_pwm_timer.sv */
module wdc_pwm_timer #(
  parameter int PERIOD = wdc_pkg::PWM_PERIOD_CYC,
  parameter int BLANK = wdc_pkg::BLANK_CYC,
  parameter int MIXPT = wdc_pkg::MIX_POINT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  wdc_timer_if.source tmr
);
  import wdc_pkg::*;
  logic [CNT_W-1:0] cnt_q;

  // free-running period counter, held at zero while idle
  always_ff @(posedge clk) begin
    if (!nrst || !run) begin
      cnt_q <= '0;
    end else if (cnt_q == CNT_W'(PERIOD - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign tmr.periodStart = run && (cnt_q == '0);
  assign tmr.inBlank = cnt_q < CNT_W'(BLANK);
  assign tmr.pastMix = cnt_q >= CNT_W'(MIXPT);
endmodule

/* File: hdl/wdc_chopper.sv */
module wdc_chopper #(
  parameter int PERIOD = wdc_pkg::PWM_PERIOD_CYC,
  parameter int BLANK = wdc_pkg::BLANK_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic output_enable_n,
  input wire logic indexer_clear_n,
  input wire logic decayPinIn,
  input wire logic decayPinDriven,
  input wire logic chop_threshold,
  input wire logic nearZero,
  input wire logic driveDir,
  input wire logic currentFalling,
  input wire logic stepIn,
  output logic stepAccept,
  output logic hiA,
  output logic loA,
  output logic hiB,
  output logic loB,
  output logic bridgeEn,
  output wdc_pkg::wdc_bridge_type bridgeState,
  output wdc_pkg::wdc_decay_type decayMode
);
  import wdc_pkg::*;

  localparam int MIXPT = PERIOD * MIX_PCT / PCT_FULL;
  localparam int PIN_N = 7;

  // synced copies of the pins
  logic [PIN_N-1:0] pinRaw;
  logic [PIN_N-1:0] pinSync;
  logic oenS;
  logic clrS;
  logic decS;
  logic drvS;
  logic trpS;
  logic zroS;
  logic stpS;

  logic [3:0] gate_d;
  logic stepLast_q;
  logic run;
  logic tripped_q;
  logic zeroSeen_q;
  wdc_bridge_type bridge_d, bridge_q;
  wdc_decay_type mode_q;
  wdc_timer_if tmr();

  // the seven pins in pinRaw pass two flops before use; driveDir and currentFalling are read directly
  assign pinRaw = {stepIn, nearZero, chop_threshold,
                   decayPinDriven, decayPinIn,
                   indexer_clear_n, output_enable_n};
  for (genvar p = 0; p < PIN_N; p++) begin : g_sync
    logic meta_q;
    logic sync_q;
    // per-pin pair; only the second flop is read
    always_ff @(posedge clk) begin
      if (!nrst) begin
        meta_q <= PIN_SYNC_RST[p];
        sync_q <= PIN_SYNC_RST[p];
      end else begin
        meta_q <= pinRaw[p];
        sync_q <= meta_q;
      end
    end
    assign pinSync[p] = sync_q;
  end

  assign oenS = pinSync[0];
  assign clrS = pinSync[1];
  assign decS = pinSync[2];
  assign drvS = pinSync[3];
  assign trpS = pinSync[4];
  assign zroS = pinSync[5];
  assign stpS = pinSync[6];

  // stopped chopper holds the timer at zero
  assign run = !oenS && clrS;

  // step edges only recognised while enabled and not cleared
  always_ff @(posedge clk) begin
    if (!nrst || !clrS) begin
      stepLast_q <= 1'b0;
    end else begin
      stepLast_q <= stpS;
    end
  end

  // combinational pulse, so a step costs no extra cycle
  assign stepAccept = run && stpS && !stepLast_q;

  // decay select latched at each period start to avoid mid-cycle changes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_q <= DEC_MIXED;
    end else if (tmr.periodStart || !run) begin
      if (!drvS) begin
        mode_q <= DEC_MIXED;
      end else if (decS) begin
        mode_q <= DEC_FAST;
      end else begin
        mode_q <= DEC_SLOW;
      end
    end
  end
  assign decayMode = mode_q;

  wdc_pwm_timer #(
    .PERIOD(PERIOD),
    .BLANK(BLANK),
    .MIXPT(MIXPT)
  ) uTimer (
    .clk(clk),
    .nrst(nrst),
    .run(run),
    .tmr(tmr.source)
  );

  // trip latch; comparator masked in blanking, cleared at period start
  always_ff @(posedge clk) begin
    if (!nrst || !run || tmr.periodStart) begin
      tripped_q <= 1'b0;
    end else if (trpS && !tmr.inBlank) begin
      tripped_q <= 1'b1;
    end
  end

  // once near zero in fast decay, stay off to block reverse build-up
  always_ff @(posedge clk) begin
    if (!nrst || !run || tmr.periodStart) begin
      zeroSeen_q <= 1'b0;
    end else if (tripped_q && zroS) begin
      zeroSeen_q <= 1'b1;
    end
  end

  // period start drives at once; the old trip is only cleared on that edge
  always_comb begin
    if (!run) begin
      bridge_d = BR_OFF;
    end else if (!tripped_q || tmr.periodStart) begin
      bridge_d = BR_DRIVE;
    end else begin
      case (mode_q)
        DEC_SLOW: bridge_d = BR_BRAKE;
        DEC_FAST: bridge_d = zeroSeen_q ? BR_OFF : BR_REVERSE;
        DEC_MIXED: begin
          if (!currentFalling || tmr.pastMix) begin
            bridge_d = BR_BRAKE;
          end else begin
            bridge_d = zeroSeen_q ? BR_OFF : BR_REVERSE;
          end
        end
        default: bridge_d = BR_OFF;
      endcase
    end
  end

  // state and gates change on the same edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bridge_q <= BR_OFF;
    end else begin
      bridge_q <= bridge_d;
    end
  end
  assign bridgeState = bridge_q;

  // direction picks the diagonal; no leg ever has both switches on
  always_comb begin
    gate_d = GATE_OFF;
    case (bridge_d)
      BR_DRIVE: begin
        if (driveDir) begin
          gate_d = GATE_POS;
        end else begin
          gate_d = GATE_NEG;
        end
      end
      BR_REVERSE: begin
        if (driveDir) begin
          gate_d = GATE_NEG;
        end else begin
          gate_d = GATE_POS;
        end
      end
      BR_BRAKE: gate_d = GATE_LOWS;
      default: gate_d = GATE_OFF;
    endcase
  end

  // gates registered so no decode glitch reaches the drivers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {hiA, loA, hiB, loB} <= GATE_OFF;
    end else begin
      {hiA, loA, hiB, loB} <= gate_d;
    end
  end

  // enable follows any state but off
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bridgeEn <= 1'b0;
    end else begin
      bridgeEn <= bridge_d != BR_OFF;
    end
  end
endmodule

/* File: test/wdc_chopper_asserts.sv */
module wdc_chopper_asserts #(
  parameter int PERIOD = wdc_pkg::PWM_PERIOD_CYC,
  parameter int BLANK = wdc_pkg::BLANK_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic output_enable_n,
  input wire logic indexer_clear_n,
  input wire logic driveDir,
  input wire logic stepAccept,
  input wire logic hiA,
  input wire logic loA,
  input wire logic hiB,
  input wire logic loB,
  input wire logic bridgeEn,
  input wire wdc_pkg::wdc_bridge_type bridgeState,
  input wire wdc_pkg::wdc_decay_type decayMode
);
  import wdc_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // four samples cover the two-flop pin sync
  sequence s_oe_off;
    output_enable_n [*4];
  endsequence
  sequence s_clr_on;
    !indexer_clear_n [*4];
  endsequence
  chk_enable_off: assert property (s_oe_off |-> bridgeState == BR_OFF && !stepAccept)
    else $error("bridge on while disabled");
  chk_clear_off: assert property (s_clr_on |-> bridgeState == BR_OFF && !stepAccept)
    else $error("bridge on while cleared");
  chk_off_idle: assert property (
    bridgeState == BR_OFF |-> !{hiA, loA, hiB, loB} && !bridgeEn)
    else $error("gates on in off state");
  chk_brake_lows: assert property (
    bridgeState == BR_BRAKE |-> {hiA, loA, hiB, loB} == GATE_LOWS)
    else $error("brake gates wrong");
  chk_drive_dir: assert property (bridgeState == BR_DRIVE
    |-> {hiA, loA, hiB, loB} == ($past(driveDir) ? GATE_POS : GATE_NEG))
    else $error("drive gates wrong");
  chk_reverse_dir: assert property (bridgeState == BR_REVERSE
    |-> {hiA, loA, hiB, loB} == ($past(driveDir) ? GATE_NEG : GATE_POS))
    else $error("reverse gates wrong");
  chk_blank_hold: assert property ($rose(bridgeState == BR_DRIVE)
    |-> (bridgeState inside {BR_DRIVE, BR_OFF}) [*8])
    else $error("drive cut inside blanking");
  chk_mixed_only: assert property ($past(bridgeState) == BR_REVERSE
    && bridgeState == BR_BRAKE |-> decayMode == DEC_MIXED)
    else $error("fast to slow outside mixed");
endmodule
bind wdc_chopper wdc_chopper_asserts #(.PERIOD(PERIOD), .BLANK(BLANK)) u_chk (.clk, .nrst,
  .output_enable_n, .indexer_clear_n, .driveDir, .stepAccept, .hiA, .loA, .hiB, .loB,
  .bridgeEn, .bridgeState, .decayMode);

/* File: test/wdc_winding_model.sv */
module wdc_winding_model (
  input wire logic clk,
  input wire wdc_pkg::wdc_bridge_type bridgeState,
  output logic chop_threshold,
  output logic nearZero
);
  timeunit 1ns;
  timeprecision 100ps;
  import wdc_pkg::*;
  int lvl = 0;
  // brake holds current, a crude stand-in for slow recirculation
  always @(posedge clk) begin
    if (bridgeState == BR_DRIVE) lvl <= lvl + 1;
    else if (bridgeState == BR_REVERSE && lvl > 1) lvl <= lvl - 2;
  end
  assign chop_threshold = lvl >= 12;
  assign nearZero = lvl < 2;
endmodule

/* File: test/tb_winding_decay_chopper.sv */
module tb_winding_decay_chopper;
  timeunit 1ns;
  timeprecision 100ps;
  import wdc_pkg::*;
  localparam int PER = 40;
  logic clk = 0, nrst = 0, oeN = 0, clrN = 1, pin = 0, drv = 1, dir = 1;
  logic fall = 0, step = 0, nzOk = 1, thr, nz, acc, hiA, loA, hiB, loB, en;
  wdc_bridge_type bs;
  wdc_decay_type dm;
  int num_errors = 0, cmp_count = 0, cyc = 0, t0, accN = 0;
  wdc_chopper #(.PERIOD(PER), .BLANK(8)) i_dut (.clk, .nrst, .output_enable_n(oeN),
    .indexer_clear_n(clrN), .decayPinIn(pin), .decayPinDriven(drv), .chop_threshold(thr),
    .nearZero(nz & nzOk), .driveDir(dir), .currentFalling(fall), .stepIn(step),
    .stepAccept(acc), .hiA, .loA, .hiB, .loB, .bridgeEn(en), .bridgeState(bs),
    .decayMode(dm));
  wdc_winding_model i_mot (.clk, .bridgeState(bs), .chop_threshold(thr), .nearZero(nz));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (acc === 1'b1) accN++;
  always @(posedge clk) if (++cyc == 20000) report_and_stop(1);
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // bounded poll; a miss shows up in the compare that follows
  task automatic wait_bs(wdc_bridge_type s);
    int i = 0;
    while (bs !== s && i++ < 200) tick();
  endtask
  task automatic decay_select();
    wdc_decay_type m [4] = '{DEC_SLOW, DEC_FAST, DEC_MIXED, DEC_MIXED};
    wdc_bridge_type s [4] = '{BR_BRAKE, BR_REVERSE, BR_REVERSE, BR_BRAKE};
    for (int k = 0; k < 4; k++) begin
      {drv, pin, fall, dir} = {k < 2, k == 1, k == 2, k[0]};
      tick(2 * PER);
      wait_bs(s[k]);
      wait_bs(BR_DRIVE);
      t0 = cyc;
      wait_bs(s[k]);
      cmp(16'(bs), 16'(s[k]));
      cmp(16'(dm), 16'(m[k]));
      wait_bs(BR_DRIVE);
      cmp(16'(cyc - t0), 16'(PER));
    end
  endtask
  task automatic mixed_switch();
    {nzOk, drv, fall} = 3'h1;
    tick(2 * PER);
    wait_bs(BR_REVERSE);
    wait_bs(BR_DRIVE);
    t0 = cyc;
    wait_bs(BR_BRAKE);
    cmp(16'(cyc - t0), 16'(PER * 3 / 4));
    nzOk = 1;
  endtask
  task automatic step_pulse(int n);
    step = 1;
    tick(4);
    step = 0;
    tick(4);
    cmp(16'(accN), 16'(n));
  endtask
  task automatic disable_stop();
    oeN = 1;
    tick(4);
    cmp(16'(en), 16'h0);
    step_pulse(0);
    {oeN, clrN} = 2'h0;
    tick(4);
    cmp(16'(en), 16'h0);
    step_pulse(0);
    clrN = 1;
    tick(4);
    step_pulse(1);
  endtask
  task automatic report_and_stop(bit t);
    num_errors += t;
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    tick(10);
    nrst = 1;
    tick(4);
    decay_select();
    mixed_switch();
    disable_stop();
    report_and_stop(0);
  end
endmodule
